// ### src/dbcd_bridge_ctrl.sv
// Two full-bridge chopper controller with fault diagnosis
// Notes on behaviour
// - both current bits high: all drivers off
// - any current bit low: polarity picks diagonal pair
// - current bits select comparator threshold
// - over threshold: sink off, oscillator restarts
// - comparator ignored briefly after sink switch-on
// - polarity reversal: old pair off first
// - bridge A restarts at peak, B at valley
// - stopped oscillator never restarts chopped bridge
// - source overload: bridge off, flag set
// - overloaded bridge waits for next byte
// - both bridges share one error pair
// - eighth short keeps sink off until transfer
// - short retried on next seven triggers
// - short window uses one-and-half full scale
// - after PWM instant comparator only chops
// - short to ground drives second bit low
// - shorted load codes: 01 or 10
// - missing flyback after reversal: first bit low
// - no reversal open-load check at hold current
// - temperature pre-alarm: both bits low
// - diagnosis filter settles after four samples
// - short flag cleared by chopping or disable
// - hold current: reversal check blanked, PWM kept
// - control bit layout; polarity high: output one
// - current bits encode off, hold, mid, full
`timescale 1ns/100ps
`include "dbcd_params.svh"
module dbcd_bridge_ctrl
    import dbcd_pkg::*;
#(
    parameter int OSC_HALF_CYC = `DBCD_OSC_HALF_CYC
) (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    // Control from the serial interface
    input  wire logic [5:0] i_ctrl_byte,
    input  wire logic       i_chip_select_low_rise,
    input  wire logic       i_enable_low,
    input  wire logic       i_osc_run,
    // Sense comparators, per bridge (bit 0 = A, bit 1 = B), then one shared temperature alarm
    input  wire logic [1:0] i_sense_resistor_trip,
    input  wire logic [1:0] i_sense_short,
    input  wire logic [1:0] i_src_overload,
    input  wire logic [1:0] i_flyback,
    input  wire logic       i_temp_alarm,
    // Gate drives, per bridge
    output logic [1:0]      o_upper_left_transistor,
    output logic [1:0]      o_upper_right_transistor,
    output logic [1:0]      o_lower_left_sink_transistor,
    output logic [1:0]      o_lower_right_sink_transistor,
    // Threshold select {A, B} and error bits
    output logic [3:0]      o_threshold_sel,
    output logic            o_first_error_bit,
    output logic            o_second_error_bit
);
    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    function automatic dbcd_cur_t cur_of(input logic [5:0] c,
                                         input logic       sel);
        cur_of = sel ? c[`DBCD_B_CUR_MSB:`DBCD_B_CUR_LSB]
                     : c[`DBCD_A_CUR_MSB:`DBCD_A_CUR_LSB];
    endfunction

    function automatic logic pol_of(input logic [5:0] c,
                                    input logic       sel);
        pol_of = sel ? c[`DBCD_B_POL] : c[`DBCD_A_POL];
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    dbcd_br_state_e state_q [2];
    dbcd_br_state_e state_d [2];
    logic [3:0]     scnt_q  [2];
    logic [3:0]     scnt_d  [2];
    logic [3:0]     hist_q  [2];
    logic [3:0]     hist_d  [2];
    logic [7:0]     rcnt_q  [2];
    logic [7:0]     rcnt_d  [2];
    logic [1:0]     stv_q, stv_d, gnd_q, gnd_d;
    logic [1:0]     fly_q, fly_d, pol_q, pol_d;
    logic [1:0]     ul_d, ur_d, lls_d, lrs_d;
    logic [1:0]     start, blank, win_short, win_pwm;
    logic [3:0]     thr_d;
    logic           osc_max, osc_min, open_any;
    logic           err1_d, err2_d;

    // ----------------------------------------------------------------
    // Oscillator and switch-on timers
    // ----------------------------------------------------------------
    dbcd_osc_tick #(.HALF_CYC(OSC_HALF_CYC)) u_osc (
        .i_mclk     (i_mclk),
        .i_reset_n  (i_reset_n),
        .i_run      (i_osc_run),
        .o_max_tick (osc_max),
        .o_min_tick (osc_min)
    );

    for (genvar g = 0; g < 2; g++) begin : g_tmr
        dbcd_on_timer u_tmr (
            .i_mclk      (i_mclk),
            .i_reset_n   (i_reset_n),
            .i_start     (start[g]),
            .o_blank     (blank[g]),
            .o_short_win (win_short[g]),
            .o_pwm_win   (win_pwm[g])
        );
    end

    // ----------------------------------------------------------------
    // Bridge sequencing
    // ----------------------------------------------------------------
    always_comb begin : bridge_next
        dbcd_cur_t cur;
        logic      pol;
        logic      trig;
        logic      smp;
        logic      miss;
        logic      src;
        logic      snk;
        cur  = 2'h0;
        pol  = 1'h0;
        trig = 1'h0;
        smp  = 1'h0;
        miss = 1'h0;
        src  = 1'h0;
        snk  = 1'h0;
        thr_d = {cur_of(i_ctrl_byte, 1'h0),
                 cur_of(i_ctrl_byte, 1'h1)};
        for (int b = 0; b < 2; b++) begin
            cur  = cur_of(i_ctrl_byte, 1'(b));
            pol  = pol_of(i_ctrl_byte, 1'(b));
            trig = (b == 0) ? osc_max : osc_min;
            smp  = 1'h0;
            miss = 1'h0;
            state_d[b] = state_q[b];
            scnt_d[b]  = scnt_q[b];
            hist_d[b]  = hist_q[b];
            rcnt_d[b]  = rcnt_q[b];
            stv_d[b]   = stv_q[b];
            gnd_d[b]   = gnd_q[b];
            fly_d[b]   = fly_q[b] | i_flyback[b];
            pol_d[b]   = pol;
            // A new byte releases the short counter and ground flag
            if (i_chip_select_low_rise) begin
                scnt_d[b] = 4'h0;
                gnd_d[b]  = 1'h0;
            end
            case (state_q[b])
                BR_IDLE: begin
                    if (cur != `DBCD_CUR_OFF) begin
                        state_d[b] = BR_ON;
                    end
                end
                BR_ON, BR_CHOP: begin
                    if (cur == `DBCD_CUR_OFF) begin
                        state_d[b] = BR_IDLE;
                    end else if (pol != pol_q[b]) begin
                        state_d[b] = BR_REV;
                        rcnt_d[b]  = 8'h0;
                        fly_d[b]   = 1'h0;
                    end else if (i_src_overload[b]) begin
                        state_d[b] = BR_TRIP;
                        gnd_d[b]   = 1'h1;
                    end else if (state_q[b] == BR_CHOP) begin
                        // No tick, no restart: oscillator stop parks it
                        if (trig) begin
                            state_d[b] = BR_ON;
                            smp  = 1'h1;
                            miss = ~fly_q[b];
                        end
                    end else if (win_short[b] && i_sense_short[b]) begin
                        state_d[b] = BR_CHOP;
                        stv_d[b]   = 1'h1;
                        fly_d[b]   = 1'h0;
                        scnt_d[b]  = scnt_q[b] + 4'h1;
                        if (scnt_q[b] == 4'(`DBCD_SHORT_LIMIT - 1)) begin
                            state_d[b] = BR_LOCK;
                        end
                    end else if (win_pwm[b] && i_sense_resistor_trip[b])
                    begin
                        state_d[b] = BR_CHOP;
                        stv_d[b]   = 1'h0;
                        scnt_d[b]  = 4'h0;
                        fly_d[b]   = 1'h0;
                    end
                end
                BR_REV: begin
                    rcnt_d[b] = rcnt_q[b] + 8'h1;
                    if (rcnt_q[b] == 8'(`DBCD_REV_CYC - 1)) begin
                        smp  = 1'h1;
                        // Low flyback energy at hold current is unreliable
                        miss = ~fly_q[b] && (cur != `DBCD_CUR_HOLD)
                               && (cur != `DBCD_CUR_OFF);
                        state_d[b] = (cur == `DBCD_CUR_OFF) ? BR_IDLE
                                                             : BR_ON;
                    end
                end
                BR_TRIP: begin
                    if (i_chip_select_low_rise) begin
                        state_d[b] = BR_IDLE;
                    end
                end
                BR_LOCK: begin
                    if (cur == `DBCD_CUR_OFF || i_chip_select_low_rise)
                    begin
                        state_d[b] = BR_IDLE;
                    end
                end
                default: state_d[b] = BR_IDLE;
            endcase
            if (smp) begin
                hist_d[b] = {hist_q[b][2:0], miss};
            end
            if (i_enable_low) begin
                state_d[b] = BR_IDLE;
                scnt_d[b]  = 4'h0;
                hist_d[b]  = `DBCD_FILT_RST;
                stv_d[b]   = 1'h0;
                gnd_d[b]   = 1'h0;
                fly_d[b]   = 1'h0;
            end
            start[b] = (state_d[b] == BR_ON) && (state_q[b] != BR_ON);
            src = (state_d[b] == BR_ON) || (state_d[b] == BR_CHOP)
                  || (state_d[b] == BR_LOCK);
            snk = state_d[b] == BR_ON;
            ul_d[b]  = src & pol;
            lls_d[b] = snk & pol;
            ur_d[b]  = src & ~pol;
            lrs_d[b] = snk & ~pol;
        end
    end

    // ----------------------------------------------------------------
    // Shared error code
    // ----------------------------------------------------------------
    always_comb begin : err_next
        open_any = 1'h0;
        for (int b = 0; b < 2; b++) begin
            open_any = open_any
                       | ((|hist_q[b]) & (state_q[b] != BR_IDLE));
        end
        err1_d = 1'h1;
        err2_d = 1'h1;
        if (i_temp_alarm) begin
            err1_d = 1'h0;
            err2_d = 1'h0;
        end else if (|gnd_q) begin
            err2_d = 1'h0;
        end else if ((|stv_q) | open_any) begin
            err1_d = 1'h0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int b = 0; b < 2; b++) begin
                state_q[b] <= BR_IDLE;
                scnt_q[b]  <= 4'h0;
                hist_q[b]  <= `DBCD_FILT_RST;
                rcnt_q[b]  <= 8'h0;
            end
            stv_q  <= 2'h0;
            gnd_q  <= 2'h0;
            fly_q  <= 2'h0;
            pol_q  <= 2'h0;
            o_upper_left_transistor       <= 2'h0;
            o_upper_right_transistor      <= 2'h0;
            o_lower_left_sink_transistor  <= 2'h0;
            o_lower_right_sink_transistor <= 2'h0;
            o_threshold_sel    <= {`DBCD_CUR_OFF, `DBCD_CUR_OFF};
            o_first_error_bit  <= `DBCD_ERR_RST;
            o_second_error_bit <= `DBCD_ERR_RST;
        end else begin
            state_q <= state_d;
            scnt_q  <= scnt_d;
            hist_q  <= hist_d;
            rcnt_q  <= rcnt_d;
            stv_q   <= stv_d;
            gnd_q   <= gnd_d;
            fly_q   <= fly_d;
            pol_q   <= pol_d;
            o_upper_left_transistor       <= ul_d;
            o_upper_right_transistor      <= ur_d;
            o_lower_left_sink_transistor  <= lls_d;
            o_lower_right_sink_transistor <= lrs_d;
            o_threshold_sel    <= thr_d;
            o_first_error_bit  <= err1_d;
            o_second_error_bit <= err2_d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    sequence s_a_steady;
        !i_enable_low && cur_of(i_ctrl_byte, 1'h0) != `DBCD_CUR_OFF
        && pol_of(i_ctrl_byte, 1'h0) == pol_q[0];
    endsequence
    sequence s_trip_wait;
        state_q[0] == BR_TRIP && !i_chip_select_low_rise && !i_enable_low;
    endsequence

    chk_off_all_drv: assert property (
        cur_of(i_ctrl_byte, 1'h0) == `DBCD_CUR_OFF |=>
        !o_upper_left_transistor[0] && !o_upper_right_transistor[0]
        && !o_lower_left_sink_transistor[0]
        && !o_lower_right_sink_transistor[0])
        else $error("bridge A driven while current off");
    chk_no_cross: assert property (
        o_upper_left_transistor[1] |->
        !o_upper_right_transistor[1] && !o_lower_right_sink_transistor[1])
        else $error("bridge B wrong diagonal pair");
    chk_comp_blank: assert property (
        (state_q[0] == BR_ON && state_d[0] == BR_CHOP) |-> !blank[0])
        else $error("chop inside blanking interval");
    chk_rev_pair_off: assert property (
        (!i_enable_low && state_q[0] == BR_ON && pol_of(i_ctrl_byte, 1'h0)
         != pol_q[0] && cur_of(i_ctrl_byte, 1'h0) != `DBCD_CUR_OFF)
        |=> !o_upper_left_transistor[0] && !o_upper_right_transistor[0])
        else $error("old pair left on at reversal");
    chk_a_phase: assert property (
        (state_q[0] == BR_CHOP && state_d[0] == BR_ON) |-> osc_max)
        else $error("bridge A restarted off the peak");
    chk_b_phase: assert property (
        (state_q[1] == BR_CHOP && state_d[1] == BR_ON) |-> osc_min)
        else $error("bridge B restarted off the valley");
    chk_trip_wait: assert property (
        s_trip_wait |=> state_q[0] == BR_TRIP)
        else $error("tripped bridge left without transfer");
    chk_gnd_report: assert property (
        (s_a_steady and (state_q[0] == BR_ON && i_src_overload[0]))
        |=> ##1 !o_second_error_bit)
        else $error("overload not reported");
    chk_lock_eight: assert property (
        (s_a_steady and (state_q[0] == BR_ON && !i_src_overload[0]
         && win_short[0] && i_sense_short[0] && scnt_q[0] == 4'h7))
        |=> state_q[0] == BR_LOCK && !o_lower_left_sink_transistor[0]
            && !o_lower_right_sink_transistor[0])
        else $error("eighth short did not lock sink");
    chk_temp_code: assert property (
        i_temp_alarm |=> !o_first_error_bit && !o_second_error_bit)
        else $error("pre-alarm code wrong");
    chk_ok_code: assert property (
        (!i_temp_alarm && gnd_q == 2'h0 && stv_q == 2'h0 && !open_any)
        |=> o_first_error_bit && o_second_error_bit)
        else $error("error bits low without fault");
endmodule // dbcd_bridge_ctrl

// ### shared/dbcd_params.svh
// Constants for the dual bridge chopper and diagnosis block
`ifndef DBCD_PARAMS_SVH
`define DBCD_PARAMS_SVH
// ----------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------
`define DBCD_CLK_NS       4
`define DBCD_CLK_HZ       250000000
`define DBCD_OSC_HZ       25000
`define DBCD_T_SHORT_NS   2000
`define DBCD_T_PWM_NS     5000
`define DBCD_T_REV_NS     1000
`define DBCD_CEIL_CYC(ns) (((ns) + `DBCD_CLK_NS - 1) / `DBCD_CLK_NS)
`define DBCD_SHORT_CYC    `DBCD_CEIL_CYC(`DBCD_T_SHORT_NS)
`define DBCD_PWM_CYC      `DBCD_CEIL_CYC(`DBCD_T_PWM_NS)
`define DBCD_REV_CYC      `DBCD_CEIL_CYC(`DBCD_T_REV_NS)
`define DBCD_OSC_HALF_CYC (`DBCD_CLK_HZ / (2 * `DBCD_OSC_HZ))
// ----------------------------------------------------------------
// Counts, fields and reset values
// ----------------------------------------------------------------
`define DBCD_SHORT_LIMIT  8
`define DBCD_FILT_RST     4'hF
`define DBCD_A_CUR_MSB    5
`define DBCD_A_CUR_LSB    4
`define DBCD_A_POL        3
`define DBCD_B_CUR_MSB    2
`define DBCD_B_CUR_LSB    1
`define DBCD_B_POL        0
`define DBCD_CUR_OFF      2'h3
`define DBCD_CUR_HOLD     2'h2
`define DBCD_ERR_RST      1'h1
`endif

// ### shared/dbcd_pkg.sv
// Types for the dual bridge chopper and diagnosis block
package dbcd_pkg;
    typedef enum logic [2:0] {
        BR_IDLE = 3'h0,
        BR_ON   = 3'h1,
        BR_CHOP = 3'h2,
        BR_REV  = 3'h3,
        BR_TRIP = 3'h4,
        BR_LOCK = 3'h5
    } dbcd_br_state_e;
    typedef logic [1:0] dbcd_cur_t;
endpackage

// ### src/dbcd_osc_tick.sv
// Oscillator trigger source: one tick at each peak and each valley
`timescale 1ns/100ps
`include "dbcd_params.svh"
module dbcd_osc_tick #(
    parameter int HALF_CYC = `DBCD_OSC_HALF_CYC
) (
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    // Oscillator running
    input  wire logic i_run,
    // Trigger ticks
    output logic      o_max_tick,
    output logic      o_min_tick
);
    localparam int W = $clog2(HALF_CYC);
    logic [W-1:0] cnt_q, cnt_d;
    logic         rise_q, rise_d;
    logic         max_d, min_d;

    always_comb begin
        cnt_d  = cnt_q;
        rise_d = rise_q;
        max_d  = 1'h0;
        min_d  = 1'h0;
        // A stopped oscillator holds its phase and gives no ticks
        if (i_run) begin
            if (cnt_q == W'(HALF_CYC - 1)) begin
                cnt_d  = '0;
                rise_d = ~rise_q;
                max_d  = rise_q;
                min_d  = ~rise_q;
            end else begin
                cnt_d = cnt_q + 1'h1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_q      <= '0;
            rise_q     <= 1'h1;
            o_max_tick <= 1'h0;
            o_min_tick <= 1'h0;
        end else begin
            cnt_q      <= cnt_d;
            rise_q     <= rise_d;
            o_max_tick <= max_d;
            o_min_tick <= min_d;
        end
    end

    chk_stop_no_tick: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) !i_run |=> !o_max_tick && !o_min_tick)
        else $error("tick while oscillator stopped");
endmodule // dbcd_osc_tick

// ### src/dbcd_on_timer.sv
// Time since sink switch-on: blanking, short check and PWM windows
`timescale 1ns/100ps
`include "dbcd_params.svh"
module dbcd_on_timer #(
    parameter int SHORT_CYC = `DBCD_SHORT_CYC,
    parameter int PWM_CYC   = `DBCD_PWM_CYC
) (
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    // Sink switched on
    input  wire logic i_start,
    // Windows
    output logic      o_blank,
    output logic      o_short_win,
    output logic      o_pwm_win
);
    localparam int W = $clog2(PWM_CYC + 1);
    logic [W-1:0] cnt_q, cnt_d;
    logic         blank_d, short_d, pwm_d;

    always_comb begin
        if (i_start) begin
            cnt_d = '0;
        end else if (cnt_q == W'(PWM_CYC)) begin
            cnt_d = cnt_q;
        end else begin
            cnt_d = cnt_q + 1'h1;
        end
        blank_d = cnt_d < W'(SHORT_CYC);
        short_d = (cnt_d >= W'(SHORT_CYC))
                  && (cnt_d < W'(PWM_CYC));
        pwm_d   = cnt_d == W'(PWM_CYC);
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_q       <= W'(PWM_CYC);
            o_blank     <= 1'h0;
            o_short_win <= 1'h0;
            o_pwm_win   <= 1'h1;
        end else begin
            cnt_q       <= cnt_d;
            o_blank     <= blank_d;
            o_short_win <= short_d;
            o_pwm_win   <= pwm_d;
        end
    end

    chk_blank_span: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        i_start |=> (o_blank && !o_pwm_win)[*8])
        else $error("comparator not blanked after switch-on");
endmodule // dbcd_on_timer

// ### test/dbcd_motor_model.sv
// Winding and sense comparator model for both bridges
`timescale 1ns/100ps
module dbcd_motor_model (
    // Gate drives seen at the bridges
    input  wire logic [1:0] i_src,
    input  wire logic [1:0] i_sink,
    // Load condition set by the bench: chop shared by both bridges, the rest per bridge
    input  wire logic       i_chop,
    input  wire logic [1:0] i_short_vs,
    input  wire logic [1:0] i_short_gnd,
    input  wire logic [1:0] i_open,
    // Comparator outputs
    output logic [1:0]      o_trip,
    output logic [1:0]      o_short,
    output logic [1:0]      o_overload,
    output logic [1:0]      o_flyback
);
    // Current crosses the threshold at once: harsher than a winding
    assign o_trip     = i_sink & {2{i_chop}};
    assign o_short    = i_sink & i_short_vs;
    assign o_overload = i_src & i_short_gnd;
    // Flyback only while the sink is off and the winding is intact
    assign o_flyback  = ~i_sink & ~i_open;
endmodule // dbcd_motor_model

// ### test/dbcd_bridge_ctrl_test.sv
// Self-checking bench for the bridge chopper and diagnosis block
`timescale 1ns/100ps
module dbcd_bridge_ctrl_test;
    localparam int HALF = 20;
    logic       i_mclk = 1'b0;
    logic       i_reset_n = 1'b0;
    logic [5:0] ctrl = 6'h3F;
    logic       csel = 1'b0;
    logic       enl = 1'b0;
    logic       run = 1'b1;
    logic       temp = 1'b0;
    logic       chop = 1'b0;
    logic [1:0] svs = 2'h0;
    logic [1:0] sgnd = 2'h0;
    logic [1:0] opn = 2'h0;
    logic [1:0] ul, ur, lls, lrs, trip, sht, ovl, fly;
    logic [3:0] thr;
    logic       e1, e2;
    int         mismatches = 0;
    int         checks = 0;
    int         cyc = 0;
    wire  [7:0] dv  = {ul, ur, lls, lrs};
    wire  [1:0] err = {e1, e2};
    // ----------------------------------------------------------------
    // Clock, instances and hang guard
    // ----------------------------------------------------------------
    initial forever #2 i_mclk = ~i_mclk;
    dbcd_bridge_ctrl #(.OSC_HALF_CYC(HALF)) dut (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ctrl_byte(ctrl),
        .i_chip_select_low_rise(csel), .i_enable_low(enl),
        .i_osc_run(run), .i_sense_resistor_trip(trip),
        .i_sense_short(sht), .i_src_overload(ovl), .i_flyback(fly),
        .i_temp_alarm(temp), .o_upper_left_transistor(ul),
        .o_upper_right_transistor(ur),
        .o_lower_left_sink_transistor(lls),
        .o_lower_right_sink_transistor(lrs), .o_threshold_sel(thr),
        .o_first_error_bit(e1), .o_second_error_bit(e2));
    dbcd_motor_model model (
        .i_src(ul | ur), .i_sink(lls | lrs), .i_chop(chop),
        .i_short_vs(svs), .i_short_gnd(sgnd), .i_open(opn),
        .o_trip(trip), .o_short(sht), .o_overload(ovl), .o_flyback(fly));
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            mismatches++;
            test_done();
        end
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic test_done();
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic put(input logic [5:0] v);
        @(posedge i_mclk) ctrl <= v;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    task automatic cs_pulse();
        @(posedge i_mclk) csel <= 1'b1;
        @(posedge i_mclk) csel <= 1'b0;
    endtask
    // Bounded wait, then the code is judged whatever it reads
    task automatic wait_err(input logic [1:0] e, input int n);
        for (int k = 0; k < n && err !== e; k++) @(negedge i_mclk);
        check(8'(err), 8'(e));
    endtask
    task automatic wait_sink(input int b, input logic v, input int n);
        for (int k = 0; k < n && (lls[b] | lrs[b]) !== v; k++)
            @(negedge i_mclk);
    endtask
    // Reversal sequence holds the bridge off 250 cycles each time
    task automatic flips(input int n);
        repeat (n) begin
            put(ctrl ^ 6'h08);
            wt(300);
        end
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic sc_decode();
        check(dv, 8'h00);
        check(8'(thr), 8'h0F);
        check(8'(err), 8'h03);
        put(6'h32);
        wt(2);
        check(dv, 8'h22);
        check(8'(thr), 8'h0D);
        put(6'h3F);
        wt(2);
        check(dv, 8'h00);
    endtask
    task automatic sc_open();
        put(6'h0E);
        wt(2);
        check(dv, 8'h44);
        put(6'h06);
        wt(10);
        check(dv, 8'h00);
        wt(260);
        check(dv, 8'h11);
        flips(4);
        check(8'(err), 8'h03);
        @(posedge i_mclk) opn <= 2'h1;
        flips(1);
        wait_err(2'h1, 4);
        @(posedge i_mclk) opn <= 2'h0;
        flips(4);
        check(8'(err), 8'h03);
        // Open winding reversed at hold current must not be reported
        @(posedge i_mclk) opn <= 2'h1;
        put(6'h26);
        wt(300);
        check(8'(err), 8'h03);
        @(posedge i_mclk) opn <= 2'h0;
        put(6'h0E);
        wt(300);
        check(dv, 8'h44);
    endtask
    task automatic sc_over();
        @(posedge i_mclk) sgnd <= 2'h1;
        wt(4);
        check(dv, 8'h00);
        wait_err(2'h2, 4);
        @(posedge i_mclk) sgnd <= 2'h0;
        wt(50);
        check(dv, 8'h00);
        cs_pulse();
        wt(4);
        check(dv, 8'h44);
        wait_err(2'h3, 4);
    endtask
    task automatic sc_short();
        @(posedge i_mclk) svs <= 2'h1;
        wait_err(2'h1, 1300);
        wt(5000);
        check(dv, 8'h40);
        @(posedge i_mclk) svs <= 2'h0;
        cs_pulse();
        wt(4);
        check(dv, 8'h44);
        wt(300);
        check(8'(err), 8'h01);
        @(posedge i_mclk) enl <= 1'b1;
        wt(3);
        check(dv, 8'h00);
        check(8'(err), 8'h03);
        @(posedge i_mclk) enl <= 1'b0;
    endtask
    task automatic sc_temp();
        wt(3);
        @(posedge i_mclk) temp <= 1'b1;
        wait_err(2'h0, 4);
        check(dv, 8'h44);
        @(posedge i_mclk) temp <= 1'b0;
    endtask
    // Peak and valley restarts must sit half a period apart
    task automatic sc_chop();
        int ta;
        put(6'h08);
        @(posedge i_mclk) chop <= 1'b1;
        wt(600);
        check(8'(lrs[1]), 8'h01);
        wait_sink(0, 1'b0, 1300);
        wait_sink(0, 1'b1, 50);
        ta = cyc;
        wait_sink(1, 1'b0, 1300);
        check(8'(lrs[1]), 8'h00);
        wait_sink(1, 1'b1, 50);
        check(8'((cyc - ta) % (2 * HALF)), 8'(HALF));
        @(posedge i_mclk) run <= 1'b0;
        wt(1400);
        check(8'({lls[0], lrs[1]}), 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        wt(1);
        sc_decode();
        sc_open();
        sc_over();
        sc_short();
        sc_temp();
        sc_chop();
        test_done();
    end
endmodule // dbcd_bridge_ctrl_test
